/* rtl/usart_datapath.sv */
// Operation
// - tx_enable set: drive serial out pin as transmitter output
// - data write loads buffer; moves to shifter when idle or after stop
// - shifter sends full frame at baud, double speed, or external clock rate
// - synchronous mode: transmitter clocks on sync clock pin, an input only
// - unused upper bits of written data ignored for short characters
// - empty flag one when tx buffer empty, zero while holding data
// - data register write clears the empty flag
// - empty interrupt request is a level while enabled and flag set
// - complete flag sets when frame left shifter and buffer empty
// - complete flag clears on interrupt service or writing one
// - complete interrupt requested when flag set and enabled
// - parity bit inserted after last data bit, before first stop
// - transmitter disable waits for shifter and buffer to drain
// - rx_enable set: serial in pin is receiver input
// - synchronous mode: receiver clocks on sync clock pin
// - frame begins on valid start bit; bits sampled and shifted in
// - second stop bit never examined by receiver
// - after first stop bit, shifter moves into receive buffer
// - short characters read with upper bits zero
// - start bit low then data bits least significant first
// - parity is xor of data, inverted for odd
// - receive complete flag one while unread data buffered
//
// Added by the designer: the address-and-strobe port and the placing of the registers.
module usart_datapath (
  input  wire logic                  clk,          // system clock
  input  wire logic                  rst_n,        // async reset
  input  wire usart_pkg::usart_bus_s bus,          // register port
  output logic [7:0]                 rdata,        // read data, cycle after rd
  input  wire logic                  rxdPin,       // serial in pin
  input  wire logic                  xckIn,        // sync clock pin input
  output usart_pkg::usart_pins_s     pins,         // serial out and clock pins
  output logic                       udreIrq,      // empty request level
  output logic                       txcIrq,       // complete request level
  input  wire logic                  txcIrqAck     // complete interrupt serviced
);
  import usart_pkg::*;

  typedef enum logic [3:0] {
    TX_IDLE = 4'b0001, TX_START = 4'b0010, TX_DATA = 4'b0100, TX_TAIL = 4'b1000
  } usart_tx_e;
  typedef enum logic [2:0] {
    RX_IDLE = 3'b001, RX_START = 3'b010, RX_BITS = 3'b100
  } usart_rx_e;

  logic [7:0]  ctrlB_q, ctrlC_q;
  logic [11:0] baud_q;
  logic        u2x_q;
  logic [8:0]  txBuf_q;
  logic        txFull_q;
  logic        txc_q;
  logic [8:0]  rxBuf_q;
  logic        rxFull_q;

  wire logic [2:0] csz    = {ctrlB_q[CB_CSZ2], ctrlC_q[CC_CSZ1], ctrlC_q[CC_CSZ0]};
  wire logic [3:0] nBits  = usart_nbits(csz);
  wire logic       syncM  = ctrlC_q[CC_SYNC];
  wire logic       txEn   = ctrlB_q[CB_TXEN];
  wire logic       rxEn   = ctrlB_q[CB_RXEN];
  wire logic       wrData = bus.wr && bus.addr == ADDR_DATA;
  wire logic       rdData = bus.rd && bus.addr == ADDR_DATA;

  // two-flop synchronisers for pins
  logic [1:0] rxdSync_q, xckSync_q;
  logic       xckLast_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxdSync_q <= 2'h3;
      xckSync_q <= 2'h0;
      xckLast_q <= 1'b0;
    end else begin
      rxdSync_q <= {rxdSync_q[0], rxdPin};
      xckSync_q <= {xckSync_q[0], xckIn};
      xckLast_q <= xckSync_q[1];
    end
  end
  wire logic rxd    = rxdSync_q[1];
  wire logic xckRise = xckSync_q[1] && !xckLast_q;
  wire logic xckFall = !xckSync_q[1] && xckLast_q;
  // change edge and sample edge, chosen by polarity
  wire logic xckChg  = ctrlC_q[CC_CPOL] ? xckFall : xckRise;
  wire logic xckSmp  = ctrlC_q[CC_CPOL] ? xckRise : xckFall;

  // register writes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrlB_q <= CTRL_B_RST;
      ctrlC_q <= CTRL_C_RST;
      baud_q  <= BAUD_RST;
      u2x_q   <= 1'b0;
    end else if (bus.wr) begin
      unique case (bus.addr)
        ADDR_CTRL_B:  ctrlB_q <= {bus.wdata[7:2], ctrlB_q[CB_RXB8], bus.wdata[0]};
        ADDR_CTRL_C:  ctrlC_q <= bus.wdata;
        ADDR_BAUD_LO: baud_q[7:0] <= bus.wdata;
        ADDR_BAUD_HI: baud_q[11:8] <= bus.wdata[3:0];
        ADDR_STATUS:  u2x_q <= bus.wdata[ST_U2X];
        default: ;
      endcase
    end
  end

  // baud tick: divisor, then 16 / 8 / 2 per bit
  logic [11:0] baudCnt_q;
  logic [3:0]  preCnt_q;
  wire logic   baudTick = baudCnt_q == 12'h000;
  wire logic [3:0] preMax = syncM ? 4'h1 : (u2x_q ? 4'h7 : 4'hF);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      baudCnt_q <= BAUD_RST;
      preCnt_q  <= 4'h0;
    end else begin
      if (baudTick || (bus.wr && bus.addr == ADDR_BAUD_LO)) baudCnt_q <= baud_q;
      else baudCnt_q <= baudCnt_q - 12'h001;
      if (baudTick) preCnt_q <= (preCnt_q >= preMax) ? 4'h0 : preCnt_q + 4'h1;
    end
  end
  wire logic asyncBit = baudTick && preCnt_q == preMax;
  // async receiver samples at the midpoint of the free-running prescaler
  wire logic asyncMid = baudTick && preCnt_q == (preMax >> 1);
  wire logic txStep = syncM ? xckChg : asyncBit;
  wire logic rxStep = syncM ? xckSmp : asyncMid;

  // transmit buffer
  logic       txLoad;
  logic       txOwn_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txBuf_q  <= 9'h000;
      txFull_q <= 1'b0;
    end else if (wrData) begin
      txBuf_q  <= usart_mask({ctrlB_q[CB_TXB8], bus.wdata}, nBits);
      txFull_q <= 1'b1;
    end else if (txLoad) begin
      txFull_q <= 1'b0;
    end
  end

  // transmit shifter
  usart_tx_e  txSt_q;
  logic [8:0] txSh_q;
  logic [3:0] txCnt_q;
  logic       txPar_q;
  logic [1:0] tailCnt_q;
  logic       txOut_q;
  wire logic  lastTail = txSt_q == TX_TAIL && txStep &&
                         tailCnt_q == (ctrlC_q[CC_STOP2] ? 2'h2 : 2'h1) + {1'b0, ctrlC_q[CC_PEN]};
  // ownership keeps loading after a disable so a pending byte is not stranded
  assign txLoad = txFull_q && (txEn || txOwn_q) && !wrData &&
                  (txSt_q == TX_IDLE || lastTail);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txSt_q <= TX_IDLE;
      txSh_q <= 9'h000;
      txCnt_q <= 4'h0;
      txPar_q <= 1'b0;
      tailCnt_q <= 2'h0;
      txOut_q <= 1'b1;
    end else begin
      unique case (txSt_q)
        TX_IDLE: begin
          txOut_q <= 1'b1;
          if (txLoad) begin
            txSh_q <= txBuf_q;
            txPar_q <= ctrlC_q[CC_PODD];
            txSt_q <= TX_START;
          end
        end
        TX_START: if (txStep) begin
          txOut_q <= 1'b0;
          txCnt_q <= 4'h0;
          txSt_q <= TX_DATA;
        end
        TX_DATA: if (txStep) begin
          txOut_q <= txSh_q[0];
          txPar_q <= txPar_q ^ txSh_q[0];
          txSh_q <= txSh_q >> 1;
          txCnt_q <= txCnt_q + 4'h1;
          tailCnt_q <= 2'h0;
          if (txCnt_q == nBits - 4'h1) txSt_q <= TX_TAIL;
        end
        TX_TAIL: if (txStep) begin
          tailCnt_q <= tailCnt_q + 2'h1;
          // parity first, then stop bits
          txOut_q <= (ctrlC_q[CC_PEN] && tailCnt_q == 2'h0) ? txPar_q : 1'b1;
          if (lastTail) begin
            if (txLoad) begin
              txSh_q <= txBuf_q;
              txPar_q <= ctrlC_q[CC_PODD];
              txSt_q <= TX_START;
            end else begin
              txSt_q <= TX_IDLE;
            end
          end
        end
        default: txSt_q <= TX_IDLE;
      endcase
    end
  end
  // last stop bit is shown for one bit time before the end counts
  wire logic frameDone = lastTail && !txLoad;

  // complete flag: set wins over clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) txc_q <= 1'b0;
    else if (frameDone && !txFull_q) txc_q <= 1'b1;
    else if (txcIrqAck || (bus.wr && bus.addr == ADDR_STATUS && bus.wdata[ST_TXC]))
      txc_q <= 1'b0;
  end

  // pin ownership; disable holds until drained
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) txOwn_q <= 1'b0;
    else if (txEn) txOwn_q <= 1'b1;
    else if (txSt_q == TX_IDLE && !txFull_q) txOwn_q <= 1'b0;
  end

  // receiver
  usart_rx_e  rxSt_q;
  logic [8:0] rxSh_q;
  logic [3:0] rxCnt_q;
  logic       rxLoad;
  wire logic  rxLast = rxCnt_q == nBits + {3'h0, ctrlC_q[CC_PEN]};
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxSt_q <= RX_IDLE;
      rxSh_q <= 9'h000;
      rxCnt_q <= 4'h0;
    end else if (!rxEn) begin
      rxSt_q <= RX_IDLE;
    end else begin
      unique case (rxSt_q)
        // async waits for falling edge then rechecks at the next prescaler midpoint
        RX_IDLE: if (syncM ? (xckSmp && !rxd) : !rxd) begin
          rxCnt_q <= 4'h0;
          rxSt_q <= syncM ? RX_BITS : RX_START;
        end
        RX_START: if (rxStep) rxSt_q <= rxd ? RX_IDLE : RX_BITS;
        RX_BITS: if (rxStep) begin
          rxCnt_q <= rxCnt_q + 4'h1;
          if (rxCnt_q < nBits) rxSh_q <= {rxd, rxSh_q[8:1]};
          if (rxLast) rxSt_q <= RX_IDLE;
        end
        default: rxSt_q <= RX_IDLE;
      endcase
    end
  end
  assign rxLoad = rxEn && rxSt_q == RX_BITS && rxStep && rxLast;

  // receive buffer; a new frame overwrites unread data
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxBuf_q  <= 9'h000;
      rxFull_q <= 1'b0;
    end else if (!rxEn) begin
      rxFull_q <= 1'b0;
    end else if (rxLoad) begin
      rxBuf_q  <= usart_mask(rxSh_q >> (4'h9 - nBits), nBits);
      rxFull_q <= 1'b1;
    end else if (rdData) begin
      rxFull_q <= 1'b0;
    end
  end

  // read port, data one cycle after strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) rdata <= 8'h00;
    else if (bus.rd) begin
      unique case (bus.addr)
        ADDR_DATA:    rdata <= rxBuf_q[7:0];
        ADDR_STATUS:  rdata <= {rxFull_q, txc_q, !txFull_q, 3'h0, u2x_q, 1'b0};
        ADDR_CTRL_B:  rdata <= {ctrlB_q[7:2], rxBuf_q[8], ctrlB_q[0]};
        ADDR_CTRL_C:  rdata <= ctrlC_q;
        ADDR_BAUD_LO: rdata <= baud_q[7:0];
        ADDR_BAUD_HI: rdata <= {4'h0, baud_q[11:8]};
        default:      rdata <= 8'h00;
      endcase
    end else rdata <= 8'h00;
  end

  // registered outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pins    <= '{txd: 1'b1, txdOe: 1'b0, xckOut: 1'b0, xckOe: 1'b0};
      udreIrq <= 1'b0;
      txcIrq  <= 1'b0;
    end else begin
      pins.txd    <= txOut_q;
      pins.txdOe  <= txOwn_q;
      pins.xckOut <= 1'b0;
      pins.xckOe  <= 1'b0;  // slave only: sync clock is an input
      udreIrq <= ctrlB_q[CB_UDRIE] && !txFull_q;
      txcIrq  <= ctrlB_q[CB_TXCIE] && txc_q;
    end
  end

endmodule : usart_datapath

/* rtl/usart_pkg.sv */
package usart_pkg;

  localparam logic [2:0] ADDR_DATA    = 3'h0;  // serial_data_reg
  localparam logic [2:0] ADDR_STATUS  = 3'h1;  // serial_status_reg
  localparam logic [2:0] ADDR_CTRL_B  = 3'h2;  // serial_control_b
  localparam logic [2:0] ADDR_CTRL_C  = 3'h3;  // serial_control_c
  localparam logic [2:0] ADDR_BAUD_LO = 3'h4;
  localparam logic [2:0] ADDR_BAUD_HI = 3'h5;

  // status bit positions
  localparam int ST_RXC   = 7;
  localparam int ST_TXC   = 6;
  localparam int ST_UDRE  = 5;
  localparam int ST_U2X   = 1;
  // control b
  localparam int CB_TXCIE = 6;
  localparam int CB_UDRIE = 5;
  localparam int CB_RXEN  = 4;
  localparam int CB_TXEN  = 3;
  localparam int CB_CSZ2  = 2;
  localparam int CB_RXB8  = 1;
  localparam int CB_TXB8  = 0;
  // control c
  localparam int CC_SYNC  = 6;
  localparam int CC_PEN   = 5;
  localparam int CC_PODD  = 4;
  localparam int CC_STOP2 = 3;
  localparam int CC_CSZ1  = 2;
  localparam int CC_CSZ0  = 1;
  localparam int CC_CPOL  = 0;

  localparam logic [7:0]  CTRL_B_RST = 8'h00;
  localparam logic [7:0]  CTRL_C_RST = 8'h06;
  localparam logic [11:0] BAUD_RST   = 12'h000;
  localparam logic [2:0]  CSZ_NINE   = 3'h7;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } usart_bus_s;

  typedef struct packed {
    logic txd;
    logic txdOe;
    logic xckOut;
    logic xckOe;
  } usart_pins_s;

  // character size code to data bit count
  function automatic logic [3:0] usart_nbits(input logic [2:0] csz);
    unique case (csz)
      3'h0:    usart_nbits = 4'h5;
      3'h1:    usart_nbits = 4'h6;
      3'h2:    usart_nbits = 4'h7;
      3'h7:    usart_nbits = 4'h9;
      default: usart_nbits = 4'h8;
    endcase
  endfunction : usart_nbits

  // clears data bits above the character size
  function automatic logic [8:0] usart_mask(input logic [8:0] d, input logic [3:0] n);
    logic [8:0] m;
    m = 9'h1FF >> (4'h9 - n);
    usart_mask = d & m;
  endfunction : usart_mask

endpackage : usart_pkg

/* tb/usart_dp_monitor.sv */
module usart_dp_monitor (
  input wire logic                   clk,      // clock
  input wire logic                   rst_n,    // reset
  input wire usart_pkg::usart_bus_s  bus,      // reg port
  input wire logic [7:0]             rdata,    // read data
  input wire logic                   rxdPin,   // serial in
  input wire logic                   xckIn,    // link clock
  input wire usart_pkg::usart_pins_s pins,     // pin outs
  input wire logic                   udreIrq,  // empty req
  input wire logic                   txcIrq,   // done req
  input wire logic                   txcIrqAck // serviced
);
  import usart_pkg::*;
  logic [3:0] sinceEdge_q;
  // slave mode: txd may only move within a few clocks of a link edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) sinceEdge_q <= 4'hF;
    else if ($changed(xckIn)) sinceEdge_q <= 4'h0;
    else if (sinceEdge_q != 4'hF) sinceEdge_q <= sinceEdge_q + 4'h1;
  end
  default clocking mcb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_data_wr;
    bus.wr && bus.addr == ADDR_DATA;
  endsequence
  sequence s_txc_wr;
    bus.wr && bus.addr == ADDR_STATUS && bus.wdata[ST_TXC];
  endsequence
  chk_udre_clear: assert property (s_data_wr |=> ##1 !udreIrq)
    else $error("empty request after data write");
  chk_udre_level: assert property (udreIrq && !bus.wr && !$past(bus.wr) |=> udreIrq)
    else $error("empty request dropped");
  chk_txc_ack: assert property (txcIrqAck |=> ##1 !txcIrq)
    else $error("done request after service");
  chk_txc_w1c: assert property (s_txc_wr |=> ##1 !txcIrq)
    else $error("done request after clear");
  chk_txc_level: assert property (txcIrq && !bus.wr && !$past(bus.wr)
    && !txcIrqAck && !$past(txcIrqAck) |=> txcIrq)
    else $error("done request dropped");
  chk_txd_tick: assert property ($changed(pins.txd) |-> sinceEdge_q <= 4'hA)
    else $error("serial out moved off the link edge");
  chk_tx_release: assert property ($fell(pins.txdOe) |-> pins.txd && $past(pins.txd))
    else $error("serial out released mid frame");
  chk_txc_idle: assert property ($rose(txcIrq) |-> pins.txd)
    else $error("done request while frame on line");
  chk_rdata_slot: assert property (!$past(bus.rd) |-> rdata == 8'h00)
    else $error("read data outside its slot");
endmodule : usart_dp_monitor

/* tb/usart_dp_partner.sv */
module usart_dp_partner (
  output logic        sync_clock_pin,  // link clock
  output logic        rxd,  // data to device
  input  wire logic   txd,  // data from device
  output logic [15:0] seen  // txd per read edge: falling edge, or rising edge when pol high
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    sync_clock_pin = 1'b0;
    rxd = 1'b1;
    seen = 16'hFFFF;
  end
  // clock stands still between bursts; 3 ns offset keeps edges off clk
  // pol high: device samples on rise, so rxd moves on fall and txd is read on rise
  task automatic burst(input logic [15:0] bits, input logic pol);
    if (pol) rxd = bits[0];
    for (int i = 0; i < 16; i++) begin
      #3 sync_clock_pin = 1'b1;
      if (pol) seen[i] = txd;
      else rxd = bits[i];
      #80 sync_clock_pin = 1'b0;
      if (pol) rxd = (i < 15) ? bits[i+1] : 1'b1;
      else seen[i] = txd;
      #77;
    end
    rxd = 1'b1;
  endtask : burst
endmodule : usart_dp_partner

/* tb/usart_tx_rx_datapath_test.sv */
module usart_tx_rx_datapath_test;
  timeunit 1ns;
  timeprecision 100ps;
  import usart_pkg::*;
  logic        clk, rst_n, txcIrqAck, sync_clock_pin, rxd, udreIrq, txcIrq;
  logic [7:0]  rdata, rv, cb;
  logic [15:0] seen, m;
  logic [2:0]  csz;
  usart_bus_s  bus;
  usart_pins_s pins;
  int          error_cnt, n_tests, seed, pos, n, txv, rxv;
  bit          pen, odd, st2, pol;
  int          rxQ[$];
  wire         txdLine = pins.txdOe ? pins.txd : 1'b1;  // pull-up once released

  usart_datapath i_usart_datapath (.clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
    .rxdPin(rxd), .xckIn(sync_clock_pin), .pins(pins), .udreIrq(udreIrq), .txcIrq(txcIrq),
    .txcIrqAck(txcIrqAck));
  usart_dp_partner i_usart_dp_partner (.sync_clock_pin(sync_clock_pin), .rxd(rxd), .txd(txdLine), .seen(seen));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // one strobe cycle, then idle; rv holds the read slot
  task automatic bus_op(input logic [2:0] a, input logic [7:0] d, input logic w);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b0, rd: 1'b0};
    #1 rv = rdata;
  endtask : bus_op

  function automatic logic [15:0] frame_bits(input int d);
    logic [15:0] f;
    int p;
    f = 16'hFFFF;
    f[0] = 1'b0;
    p = odd;
    for (int i = 0; i < n; i++) begin
      f[i+1] = d[i];
      p ^= d[i];
    end
    if (pen) f[n+1] = p[0];
    return f;
  endfunction : frame_bits

  task automatic close_out();
    if (error_cnt == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : close_out

  // ten bursts of about 2.6 us plus register traffic
  initial begin
    #100000;
    error_cnt++;
    close_out();
  end

  initial begin
    seed = 81;
    error_cnt = 0;
    n_tests = 0;
    rst_n = 1'b0;
    txcIrqAck = 1'b0;
    bus = '{addr: 3'h0, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    bus_op(ADDR_CTRL_B, 8'h00, 1'b0);
    check("ctrl_b reset", rv, CTRL_B_RST);
    bus_op(ADDR_CTRL_C, 8'h00, 1'b0);
    check("ctrl_c reset", rv, CTRL_C_RST);
    bus_op(ADDR_STATUS, 8'h00, 1'b0);
    check("status reset", rv, 8'h20);
    bus_op(3'h6, 8'h00, 1'b0);
    check("unmapped read", rv, 8'h00);
    for (int t = 0; t < 10; t++) begin
      csz = (t % 5 == 4) ? CSZ_NINE : 3'(t % 4);
      n = (csz == CSZ_NINE) ? 9 : t % 4 + 5;
      pen = t % 3 != 0;
      odd = t % 3 == 2;
      st2 = t[1];
      pol = t[0];
      txv = $random(seed) & 32'h1FF;
      rxv = $random(seed) & 32'h1FF;
      m = (16'h1 << (n + 2 + pen + st2)) - 16'h1;
      bus_op(ADDR_CTRL_C, {2'b01, pen, odd, st2, csz[1:0], pol}, 1'b1);
      cb = {4'h7, 1'b1, csz[2], 1'b0, txv[8]};
      bus_op(ADDR_CTRL_B, cb, 1'b1);
      // idle shifter takes the byte one cycle after the write, so read status at once
      @(posedge clk);
      bus <= '{addr: ADDR_DATA, wdata: txv[7:0], wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      bus <= '{addr: ADDR_STATUS, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      bus <= '{addr: ADDR_STATUS, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
      #1 rv = rdata;
      check("empty flag", rv[ST_UDRE], 1'b0);
      check("empty request", udreIrq, 1'b0);
      check("pin owned", pins.txdOe, 1'b1);
      // last pass drops the enable with a frame still pending
      if (t == 9) bus_op(ADDR_CTRL_B, cb & 8'hF7, 1'b1);
      rxQ.push_back(rxv & ((1 << n) - 1));
      i_usart_dp_partner.burst(frame_bits(rxv), pol);
      pos = 16;
      for (int i = 15; i >= 0; i--)
        if (seen[i] === 1'b0) pos = i;
      check("tx frame", (seen >> pos) & m, frame_bits(txv) & m);
      check("empty request", udreIrq, 1'b1);
      check("done request", txcIrq, 1'b1);
      bus_op(ADDR_STATUS, 8'h00, 1'b0);
      check("status flags", rv[7:5], 3'h7);
      bus_op(ADDR_CTRL_B, 8'h00, 1'b0);
      if (n == 9) check("rx ninth", rv[CB_RXB8], rxv[8]);
      bus_op(ADDR_DATA, 8'h00, 1'b0);
      check("rx data", rv, 16'(rxQ.pop_front() & 255));
      bus_op(ADDR_STATUS, 8'h00, 1'b0);
      check("rx flag", rv[ST_RXC], 1'b0);
      if (t % 2 == 1) bus_op(ADDR_STATUS, 8'h40, 1'b1);
      else begin
        @(posedge clk) txcIrqAck <= 1'b1;
        @(posedge clk) txcIrqAck <= 1'b0;
      end
      bus_op(ADDR_STATUS, 8'h00, 1'b0);
      check("done flag", rv[ST_TXC], 1'b0);
    end
    check("pin released", pins.txdOe, 1'b0);
    close_out();
  end
endmodule : usart_tx_rx_datapath_test

bind usart_datapath usart_dp_monitor i_usart_dp_monitor (.clk(clk), .rst_n(rst_n),
  .bus(bus), .rdata(rdata), .rxdPin(rxdPin), .xckIn(xckIn), .pins(pins),
  .udreIrq(udreIrq), .txcIrq(txcIrq), .txcIrqAck(txcIrqAck));
